/* common/rxc_map.vh */
// Opcode, field position, timing and reset constants for the exchange/flag slice
`ifndef RXC_MAP_VH
`define RXC_MAP_VH
`define RXC_OP_SWAP_ACC_IDX_TWO   16'h37DC
`define RXC_OP_SWAP_ACC_IDX_THREE 16'h37EC
`define RXC_OP_SWAP_AUX_IDX_ONE   16'h374C
`define RXC_OP_SWAP_AUX_IDX_TWO   16'h375C
`define RXC_OP_SWAP_AUX_IDX_THREE 16'h376C
`define RXC_SWAP_CYCLES           2'h2
`define RXC_FLAGS_HI_MSB          15
`define RXC_FLAGS_HI_LSB          4
`define RXC_BANK_MSB              3
`define RXC_BANK_LSB              0
`define RXC_RST_WORD              16'h0000
`define RXC_RST_EXT               4'h0
// Programmer-visible registers leave reset with distinct words so a swap is observable
`define RXC_RST_ACC_WIDE          16'h1111
`define RXC_RST_ACC_AUX           16'h2222
`define RXC_RST_IDX_ONE           16'h3333
`define RXC_RST_IDX_TWO           16'h4444
`define RXC_RST_IDX_THREE         16'h5555
`define RXC_RST_EXT_ONE           4'h1
`define RXC_RST_EXT_TWO           4'h2
`define RXC_RST_EXT_THREE         4'h3
`define RXC_RST_FLAGS             16'h0000
`define RXC_MODE_SHORT            2'h0
`define RXC_MODE_MID              2'h1
`define RXC_MODE_LONG             2'h2
`define RXC_FLAG_NONE             3'h0
`define RXC_FLAG_RESULT           3'h1
`define RXC_FLAG_POP_ALL          3'h2
`define RXC_FLAG_POP_BANK         3'h4
`endif

/* core/rxc_addr_gen.v */
// Indexed effective-address generator for short, medium and long offsets
`timescale 1ns/1ps
`default_nettype none
`include "rxc_map.vh"
module rxc_addr_gen (
    input  wire [1:0]  mode,
    input  wire [3:0]  idxExt,
    input  wire [15:0] idxBase,
    input  wire [19:0] offset,
    output reg  [19:0] effAddr
);
    // Full 20-bit base: extension on top of the index word
    wire [19:0] base20 = {idxExt, idxBase};

    // Offset extension per mode, then 20-bit wrapping add
    always @* begin
        if (mode == `RXC_MODE_SHORT) begin
            effAddr = base20 + {12'h000, offset[7:0]};          // [RQ8]
        end else if (mode == `RXC_MODE_MID) begin
            effAddr = base20 + {{4{offset[15]}}, offset[15:0]}; // [RQ9]
        end else begin
            effAddr = base20 + offset;                          // [RQ10] [RQ11]
        end
    end
endmodule
`default_nettype wire

/* core/rxc_exec.v */
// Exchange execution, condition-flag update and indexed address slice
`timescale 1ns/1ps
`default_nettype none
`include "rxc_map.vh"
// Summary of operation
// [RQ1] 37DC/37EC swap wide accumulator with index two/three
// [RQ2] 374C/375C/376C swap auxiliary accumulator with index
// [RQ3] Swaps take two cycles, flags untouched
// [RQ4] Result updates touch flag bits 15..4 only
// [RQ5] Branch cycles: taken count when condition true, else not-taken count
// [RQ6] Stack restore loads all sixteen flag bits
// [RQ7] Bank restore changes bank field only
// [RQ8] Short indexed: unsigned 8-bit zero-extended offset
// [RQ9] Medium indexed: signed 16-bit sign-extended offset
// [RQ10] Long indexed: signed 20-bit offset with extension
// [RQ11] Address extension fields are four bits wide
// [RQ12] Bank field sits in flag bits 3..0
// [RQ13] Both swap operands captured before writing
module rxc_exec (
    input  wire        clk,
    input  wire        rstn,
    input  wire        instValid,
    input  wire [15:0] opcode,
    input  wire [2:0]  flagOp,
    input  wire [15:0] resultFlags,
    input  wire [15:0] poppedWord,
    input  wire        branchCond,
    input  wire [3:0]  branchTakenCycles,
    input  wire [3:0]  branchNotTakenCycles,
    input  wire        isBranch,
    input  wire [1:0]  idxMode,
    input  wire [1:0]  idxSel,
    input  wire [19:0] idxOffset,
    input  wire        idxReq,
    output reg  [15:0] accWide,
    output reg  [15:0] accAux,
    output reg  [15:0] indexOne,
    output reg  [15:0] indexTwo,
    output reg  [15:0] indexThree,
    output reg  [3:0]  extOne,
    output reg  [3:0]  extTwo,
    output reg  [3:0]  extThree,
    output reg  [15:0] condFlagsReg,
    output reg         busy,
    output reg         instDone,
    output reg  [3:0]  branchCycles,
    output reg  [19:0] effAddr
);
    // Exchange sequencer states, one-hot
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_SWAP = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;

    reg  [2:0]  state;       // Sequencer state
    reg  [2:0]  swapKind;    // Which exchange is running
    reg  [15:0] capAcc;      // Captured accumulator value
    reg  [15:0] capIdx;      // Captured index value
    wire [19:0] next_effAddr;// Combinational effective address
    reg  [3:0]  selExt;      // Selected index extension
    reg  [15:0] selIdx;      // Selected index word

    // Exchange opcode decode: 0 none, 1..5 the five swaps
    function [2:0] swap_decode;
        input [15:0] op;
        begin
            if (op == `RXC_OP_SWAP_ACC_IDX_TWO)         swap_decode = 3'h1; // [RQ1]
            else if (op == `RXC_OP_SWAP_ACC_IDX_THREE)  swap_decode = 3'h2; // [RQ1]
            else if (op == `RXC_OP_SWAP_AUX_IDX_ONE)    swap_decode = 3'h3; // [RQ2]
            else if (op == `RXC_OP_SWAP_AUX_IDX_TWO)    swap_decode = 3'h4; // [RQ2]
            else if (op == `RXC_OP_SWAP_AUX_IDX_THREE)  swap_decode = 3'h5; // [RQ2]
            else                                        swap_decode = 3'h0;
        end
    endfunction

    // Index register selection for address generation
    always @* begin
        if (idxSel == 2'h1) begin
            selIdx = indexTwo;
            selExt = extTwo;
        end else if (idxSel == 2'h2) begin
            selIdx = indexThree;
            selExt = extThree;
        end else begin
            selIdx = indexOne;
            selExt = extOne;
        end
    end

    // Address adder
    rxc_addr_gen uAddr (
        .mode    (idxMode),
        .idxExt  (selExt),
        .idxBase (selIdx),
        .offset  (idxOffset),
        .effAddr (next_effAddr)
    );

    // Register the effective address on request
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            effAddr <= 20'h00000;
        end else if (idxReq) begin
            effAddr <= next_effAddr; // [RQ8] [RQ9] [RQ10]
        end
    end

    // Exchange sequencer: cycle 1 captures, cycle 2 writes both
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state    <= ST_IDLE;
            swapKind <= 3'h0;
            capAcc   <= `RXC_RST_WORD;
            capIdx   <= `RXC_RST_WORD;
            // Distinct start words, so each register's identity survives a swap
            accWide  <= `RXC_RST_ACC_WIDE;
            accAux   <= `RXC_RST_ACC_AUX;
            indexOne <= `RXC_RST_IDX_ONE;
            indexTwo <= `RXC_RST_IDX_TWO;
            indexThree <= `RXC_RST_IDX_THREE;
            extOne   <= `RXC_RST_EXT_ONE;
            extTwo   <= `RXC_RST_EXT_TWO;
            extThree <= `RXC_RST_EXT_THREE;
            busy     <= 1'b0;
            instDone <= 1'b0;
        end else begin
            instDone <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Start swap; capture both operands first
                    if (instValid && (swap_decode(opcode) != 3'h0)) begin
                        swapKind <= swap_decode(opcode);
                        case (swap_decode(opcode))
                            3'h1: begin
                                capAcc <= accWide;
                                capIdx <= indexTwo;
                            end
                            3'h2: begin
                                capAcc <= accWide;
                                capIdx <= indexThree;
                            end
                            3'h3: begin
                                capAcc <= accAux;
                                capIdx <= indexOne;
                            end
                            3'h4: begin
                                capAcc <= accAux;
                                capIdx <= indexTwo;
                            end
                            default: begin
                                capAcc <= accAux;
                                capIdx <= indexThree;
                            end
                        endcase // [RQ13]
                        busy  <= 1'b1;
                        state <= ST_SWAP;
                    end
                end
                ST_SWAP: begin
                    // Write captured values crosswise; second cycle
                    case (swapKind)
                        3'h1: begin
                            accWide  <= capIdx;
                            indexTwo <= capAcc;
                        end
                        3'h2: begin
                            accWide    <= capIdx;
                            indexThree <= capAcc;
                        end
                        3'h3: begin
                            accAux   <= capIdx;
                            indexOne <= capAcc;
                        end
                        3'h4: begin
                            accAux   <= capIdx;
                            indexTwo <= capAcc;
                        end
                        default: begin
                            accAux     <= capIdx;
                            indexThree <= capAcc;
                        end
                    endcase // [RQ1] [RQ2] [RQ3] [RQ13]
                    busy     <= 1'b0;
                    instDone <= 1'b1;
                    state    <= ST_DONE;
                end
                ST_DONE: begin
                    // Back to idle, ready next cycle
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Condition flags; swaps never reach here so flags stay intact
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            condFlagsReg <= `RXC_RST_FLAGS;
        end else if (instValid && !busy && (swap_decode(opcode) == 3'h0)) begin // [RQ3]
            if (flagOp == `RXC_FLAG_RESULT) begin
                // Upper flags from result, bank field kept
                condFlagsReg[`RXC_FLAGS_HI_MSB:`RXC_FLAGS_HI_LSB] <=
                    resultFlags[`RXC_FLAGS_HI_MSB:`RXC_FLAGS_HI_LSB]; // [RQ4] [RQ12]
            end else if (flagOp == `RXC_FLAG_POP_ALL) begin
                condFlagsReg <= poppedWord; // [RQ6]
            end else if (flagOp == `RXC_FLAG_POP_BANK) begin
                condFlagsReg[`RXC_BANK_MSB:`RXC_BANK_LSB] <=
                    poppedWord[`RXC_BANK_MSB:`RXC_BANK_LSB]; // [RQ7] [RQ12]
            end
        end
    end

    // Branch cycle count: taken figure or not-taken figure
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            branchCycles <= 4'h0;
        end else if (instValid && isBranch) begin
            branchCycles <= branchCond ? branchTakenCycles : branchNotTakenCycles; // [RQ5]
        end
    end
endmodule
`default_nettype wire

/* verif/rxc_exec_asserts.sv */
// Checker for the exchange, flag and indexed address slice
`timescale 1ns/1ps
`default_nettype none
`include "rxc_map.vh"
module rxc_exec_asserts (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        instValid,
    input wire logic [15:0] opcode,
    input wire logic [2:0]  flagOp,
    input wire logic [15:0] resultFlags,
    input wire logic [15:0] poppedWord,
    input wire logic        branchCond,
    input wire logic [3:0]  branchTakenCycles,
    input wire logic [3:0]  branchNotTakenCycles,
    input wire logic        isBranch,
    input wire logic [1:0]  idxMode,
    input wire logic [1:0]  idxSel,
    input wire logic [19:0] idxOffset,
    input wire logic        idxReq,
    input wire logic [15:0] accWide,
    input wire logic [15:0] indexOne,
    input wire logic [15:0] indexTwo,
    input wire logic [15:0] indexThree,
    input wire logic [3:0]  extOne,
    input wire logic [3:0]  extTwo,
    input wire logic [3:0]  extThree,
    input wire logic [15:0] condFlagsReg,
    input wire logic        busy,
    input wire logic        instDone,
    input wire logic [3:0]  branchCycles,
    input wire logic [19:0] effAddr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Swap opcode seen while the unit is idle
    wire logic isSwap = opcode inside {`RXC_OP_SWAP_ACC_IDX_TWO, `RXC_OP_SWAP_ACC_IDX_THREE,
        `RXC_OP_SWAP_AUX_IDX_ONE, `RXC_OP_SWAP_AUX_IDX_TWO, `RXC_OP_SWAP_AUX_IDX_THREE};
    wire logic take = instValid && !busy && !instDone;
    wire logic swapGo = take && isSwap;
    // Extension and index of the selected register
    wire logic [19:0] base = (idxSel == 2'h0) ? {extOne, indexOne} :
        (idxSel == 2'h1) ? {extTwo, indexTwo} : {extThree, indexThree};
    // Capture cycle, then write cycle with completion
    sequence swapRun;
        busy && !instDone ##1 !busy && instDone;
    endsequence
    a_swap_timing: assert property (swapGo |=> swapRun)
        else $error("swap timing wrong");
    a_swap_flags: assert property (swapGo |=> $stable(condFlagsReg) [*2])
        else $error("swap changed flags");
    a_swap_data: assert property (swapGo && opcode == `RXC_OP_SWAP_ACC_IDX_TWO |->
        ##2 accWide == $past(indexTwo, 2) && indexTwo == $past(accWide, 2))
        else $error("swap data wrong");
    a_result_flags: assert property (take && !isSwap && flagOp == `RXC_FLAG_RESULT
        |=> condFlagsReg == {$past(resultFlags[15:4]), $past(condFlagsReg[3:0])})
        else $error("result flag update wrong");
    a_pop_all: assert property (take && !isSwap && flagOp == `RXC_FLAG_POP_ALL |=>
        condFlagsReg == $past(poppedWord)) else $error("pop all wrong");
    a_pop_bank: assert property (take && !isSwap && flagOp == `RXC_FLAG_POP_BANK |=>
        condFlagsReg == {$past(condFlagsReg[15:4]), $past(poppedWord[3:0])})
        else $error("pop bank wrong");
    a_branch_count: assert property (instValid && isBranch |=> branchCycles ==
        ($past(branchCond) ? $past(branchTakenCycles) : $past(branchNotTakenCycles)))
        else $error("branch count wrong");
    a_addr_short: assert property (idxReq && idxMode == `RXC_MODE_SHORT |=>
        effAddr == $past(base) + {12'h000, $past(idxOffset[7:0])})
        else $error("short address wrong");
    a_addr_mid: assert property (idxReq && idxMode == `RXC_MODE_MID |=>
        effAddr == $past(base) + {{4{$past(idxOffset[15])}}, $past(idxOffset[15:0])})
        else $error("mid address wrong");
    a_addr_long: assert property (idxReq && idxMode == `RXC_MODE_LONG |=>
        effAddr == $past(base) + $past(idxOffset)) else $error("long address wrong");
endmodule
`default_nettype wire

/* verif/test_register_exchange_and_ccr_rules.sv */
// Self-checking bench for the exchange, flag and address slice
`timescale 1ns/1ps
`default_nettype none
`include "rxc_map.vh"
module test_register_exchange_and_ccr_rules;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        instValid = 1'b0;
    logic [15:0] opcode = 16'h0000;
    logic [2:0]  flagOp = 3'h0;
    logic [15:0] resultFlags = 16'h0000;
    logic [15:0] poppedWord = 16'h0000;
    logic        branchCond = 1'b0;
    logic [3:0]  branchTakenCycles = 4'h0;
    logic [3:0]  branchNotTakenCycles = 4'h0;
    logic        isBranch = 1'b0;
    logic [1:0]  idxMode = 2'h0;
    logic [1:0]  idxSel = 2'h0;
    logic [19:0] idxOffset = 20'h00000;
    logic        idxReq = 1'b0;
    wire  [15:0] accWide, accAux, indexOne, indexTwo, indexThree, condFlagsReg;
    wire  [3:0]  extOne, extTwo, extThree, branchCycles;
    wire         busy, instDone;
    wire  [19:0] effAddr;
    int          error_cnt = 0;
    int          total_checks = 0;
    rxc_exec DUT (.*);
    // Clock at 125 MHz
    always #4 clk = ~clk;
    // Compare one value
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Move to just after the next rising edge
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // Present an instruction over one edge, valid left high
    task automatic issue(input logic [15:0] op, input logic [2:0] fo);
        opcode = op;
        flagOp = fo;
        instValid = 1'b1;
        step();
    endtask
    // Back-to-back flag updates of every kind
    task automatic flag_updates();
        check(extOne, `RXC_RST_EXT_ONE);
        check(extTwo, `RXC_RST_EXT_TWO);
        check(extThree, `RXC_RST_EXT_THREE);
        poppedWord = 16'hA5C3;
        issue(16'h0000, `RXC_FLAG_POP_ALL);
        check(condFlagsReg, 16'hA5C3);
        resultFlags = 16'h1234;
        issue(16'h0000, `RXC_FLAG_RESULT);
        check(condFlagsReg, 16'h1233);
        poppedWord = 16'hFFF9;
        issue(16'h0000, `RXC_FLAG_POP_BANK);
        check(condFlagsReg, 16'h1239);
        issue(16'h0000, `RXC_FLAG_NONE);
        check(condFlagsReg, 16'h1239);
        instValid = 1'b0;
        step();
    endtask
    // Every swap against a register model, with a flag load attempted while busy
    task automatic swap_all();
        logic [15:0] ops [5] = '{`RXC_OP_SWAP_ACC_IDX_TWO, `RXC_OP_SWAP_ACC_IDX_THREE,
            `RXC_OP_SWAP_AUX_IDX_ONE, `RXC_OP_SWAP_AUX_IDX_TWO, `RXC_OP_SWAP_AUX_IDX_THREE};
        int          idxSlot [5] = '{3, 4, 2, 3, 4}; // Model slot of each swap's index
        logic [15:0] model [5];                      // Wide, aux, index one, two, three
        logic [15:0] held;                           // Swap temporary
        int          accSlot;                        // Model slot of the accumulator
        model = '{`RXC_RST_ACC_WIDE, `RXC_RST_ACC_AUX, `RXC_RST_IDX_ONE, `RXC_RST_IDX_TWO,
            `RXC_RST_IDX_THREE};
        poppedWord = 16'h0F0F;
        foreach (ops[i]) begin
            accSlot = (i < 2) ? 0 : 1;
            held = model[accSlot];
            model[accSlot] = model[idxSlot[i]];
            model[idxSlot[i]] = held;
            issue(ops[i], `RXC_FLAG_POP_ALL);
            check(busy, 1'b1);
            issue(16'h0000, `RXC_FLAG_POP_ALL);
            check(instDone, 1'b1);
            check(condFlagsReg, 16'h1239);
            check(accWide, model[0]);
            check(accAux, model[1]);
            check(indexOne, model[2]);
            check(indexTwo, model[3]);
            check(indexThree, model[4]);
            instValid = 1'b0;
            step();
        end
    endtask
    // Taken and not-taken cycle counts
    task automatic branch_counts();
        branchTakenCycles = 4'h6;
        branchNotTakenCycles = 4'h2;
        isBranch = 1'b1;
        branchCond = 1'b1;
        issue(16'h0000, `RXC_FLAG_NONE);
        check(branchCycles, 4'h6);
        branchCond = 1'b0;
        issue(16'h0000, `RXC_FLAG_NONE);
        check(branchCycles, 4'h2);
        instValid = 1'b0;
        isBranch = 1'b0;
        step();
    endtask
    // One address request, request left high
    task automatic addr(input logic [1:0] m, input logic [19:0] off, input logic [19:0] exp);
        idxMode = m;
        idxOffset = off;
        idxSel = m;
        idxReq = 1'b1;
        step();
        check(effAddr, exp);
    endtask
    // Verdict and end of run
    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        flag_updates();
        swap_all();
        branch_counts();
        // Bases left by the swaps: one 1:2222, two 2:3333, three 3:1111
        addr(`RXC_MODE_SHORT, 20'hFFFAB, 20'h122CD);
        addr(`RXC_MODE_MID, 20'h0FF00, 20'h23233);
        addr(`RXC_MODE_MID, 20'hF1234, 20'h24567);
        addr(`RXC_MODE_LONG, 20'h80001, 20'hB1112);
        addr(`RXC_MODE_LONG, 20'hCEEEF, 20'h00000);
        idxReq = 1'b0;
        close_out();
    end
    // Watchdog against a hang
    initial begin
        #20000;
        error_cnt++;
        close_out();
    end
endmodule
bind rxc_exec rxc_exec_asserts chk (.*);
`default_nettype wire
